/* File: logic/tcp_pkg.sv */
package tcp_pkg;

    // ========================================================
    // sizes
    // ========================================================
    localparam int          NUM_UNITS = 5;
    localparam int          CNT_W     = 16;
    localparam int          DEAD_W    = 8;
    localparam int          CTRL_W    = 8;
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam int          NUM_CMP   = 2;

    // ========================================================
    // register map: unit select in address bits 7:5
    // ========================================================
    localparam int          UNIT_LSB   = 5;
    localparam int          UNIT_W     = 3;
    localparam logic [4:0]  OFF_CTRL   = 5'h00;
    localparam logic [4:0]  OFF_PERIOD = 5'h04;
    localparam logic [4:0]  OFF_CMP    = 5'h08;
    localparam logic [4:0]  OFF_DEAD   = 5'h0C;
    localparam logic [4:0]  OFF_CAPT   = 5'h10;
    localparam logic [4:0]  OFF_STAT   = 5'h14;

    // ========================================================
    // control and status fields
    // ========================================================
    localparam int          CTL_EN      = 0;
    localparam int          CTL_ONESHOT = 1;
    localparam int          CTL_MODE_LO = 2;
    localparam int          CTL_KSRC_LO = 4;
    localparam int          CTL_SAFE_T  = 6;
    localparam int          CTL_SAFE_C  = 7;
    localparam int          STAT_RUN    = 16;
    localparam int          STAT_DOWN   = 17;

    // ========================================================
    // reset values and constants
    // ========================================================
    localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
    localparam logic [CNT_W-1:0]  PERIOD_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
    localparam logic [CNT_W-1:0]  LFSR_SEED  = 16'h0001;
    localparam logic [CNT_W-1:0]  LFSR_TAPS  = 16'hB400;
    localparam logic [DEAD_W-1:0] DEAD_ZERO  = 8'h00;
    localparam logic [DEAD_W-1:0] DEAD_ONE   = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

    typedef enum logic [1:0] {
        TCP_MODE_EDGE   = 2'b00,
        TCP_MODE_CENTER = 2'b01,
        TCP_MODE_PRNG   = 2'b10
    } tcp_mode_t;

    typedef enum logic [1:0] {
        TCP_KILL_OFF  = 2'b00,
        TCP_KILL_PIN  = 2'b01,
        TCP_KILL_CMP0 = 2'b10,
        TCP_KILL_CMP1 = 2'b11
    } tcp_ksrc_t;

endpackage : tcp_pkg

/* File: logic/tcp_dead.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_dead #(
    parameter int DEAD_W = tcp_pkg::DEAD_W
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // control
    input  wire logic              pwm_i,
    input  wire logic [DEAD_W-1:0] dead_i,
    input  wire logic              kill_i,
    input  wire logic              safe_t_i,
    input  wire logic              safe_c_i,
    // outputs
    output logic                   out_o,
    output logic                   out_n_o
);

    logic              pwm_q_r;
    logic [DEAD_W-1:0] gap_r;

    // ========================================================
    // dead band and kill
    // ========================================================
    // kill holds a pending edge so that release passes through the full dead gap, unless pwm_i
    // toggles in the release cycle: then safe levels hold for the gap and run straight into pwm levels
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwm_q_r <= 1'b0;
            gap_r   <= '0;
            out_o   <= 1'b0;
            out_n_o <= 1'b0;
        end else begin
            pwm_q_r <= pwm_i;
            if (kill_i) begin                               // see RQ6
                out_o   <= safe_t_i;
                out_n_o <= safe_c_i;
                gap_r   <= dead_i;
                pwm_q_r <= ~pwm_i;
            end else if (pwm_i != pwm_q_r) begin            // see RQ5
                out_o   <= 1'b0;
                out_n_o <= 1'b0;
                gap_r   <= dead_i;
            end else if (gap_r != '0) begin
                gap_r   <= gap_r - DEAD_W'(1);
            end else begin
                out_o   <= pwm_q_r;
                out_n_o <= ~pwm_q_r;
            end
        end
    end

    // ========================================================
    // checks
    // ========================================================
    chk_kill_force: assert property ( // see RQ6
        @(posedge clk_i) disable iff (reset_i)
        kill_i |=> (out_o == $past(safe_t_i)) && (out_n_o == $past(safe_c_i)))
        else $error("kill did not force safe levels");

    chk_no_overlap: assert property ( // see RQ5
        @(posedge clk_i) disable iff (reset_i)
        !$past(kill_i) |-> !(out_o && out_n_o))
        else $error("true and complement high together");

    chk_dead_gap: assert property ( // see RQ5
        @(posedge clk_i) disable iff (reset_i)
        (pwm_i != pwm_q_r) && !kill_i |=> !out_o && !out_n_o)
        else $error("no dead gap after edge");

    cov_dead_edge: cover property (
        @(posedge clk_i) disable iff (reset_i)
        !out_o ##1 out_o);

endmodule : tcp_dead

`default_nettype wire

/* File: logic/tcp_top.sv */
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1: each unit has a 16-bit counter whose period software sets.
// RQ2: a capture event, pin included, copies the count into capture.
// RQ3: at count equal to period the counter stops or reloads as set.
// RQ4: compare values against the count set the PWM duty.
// RQ5: true and complement outputs are parted by a programmable gap; the code skips the gap when pwm_i toggles in the kill release cycle.
// RQ6: kill forces the outputs to preset safe levels with no software.
// RQ7: five independent units are provided.
// RQ8: edge, center and pseudo-random PWM modes are selectable.
// RQ9: kill may come from a comparator output for drive protection.
// RQ10: reset clears the counter and drives both outputs inactive.
module tcp_top #(
    parameter int NUNIT = tcp_pkg::NUM_UNITS
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    // register port
    input  wire logic [tcp_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [tcp_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [tcp_pkg::DATA_W-1:0]  rdata_o,
    // events
    input  wire logic [NUNIT-1:0]            capture_i,
    input  wire logic [NUNIT-1:0]            kill_i,
    input  wire logic [tcp_pkg::NUM_CMP-1:0] cmp_i,
    // pwm outputs
    output logic      [NUNIT-1:0]            pwm_o,
    output logic      [NUNIT-1:0]            pwm_n_o
);

    localparam int            CW        = tcp_pkg::CNT_W;
    localparam logic [CW-1:0] CNT_ONE_W = tcp_pkg::CNT_ONE;

    logic [tcp_pkg::CTRL_W-1:0] ctrl_r   [NUNIT];
    logic [CW-1:0]              period_r [NUNIT];
    logic [CW-1:0]              cmp_r    [NUNIT];
    logic [tcp_pkg::DEAD_W-1:0] dead_r   [NUNIT];
    logic [CW-1:0]              capt_r   [NUNIT];
    logic [CW-1:0]              count_r  [NUNIT];
    logic [NUNIT-1:0]           run_r;
    logic [NUNIT-1:0]           down_r;
    logic [NUNIT-1:0]           cap_q_r;
    logic [CW-1:0]              lfsr_r;
    logic [tcp_pkg::DATA_W-1:0] rd_nxt;
    logic [tcp_pkg::UNIT_W-1:0] sel_unit;
    logic [4:0]                 sel_off;

    assign sel_unit = addr_i[tcp_pkg::UNIT_LSB +: tcp_pkg::UNIT_W];
    assign sel_off  = addr_i[tcp_pkg::UNIT_LSB-1:0];

    // ========================================================
    // shared pseudo-random source
    // ========================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lfsr_r <= tcp_pkg::LFSR_SEED;
        end else if (lfsr_r[0]) begin
            lfsr_r <= (lfsr_r >> 1) ^ tcp_pkg::LFSR_TAPS;
        end else begin
            lfsr_r <= lfsr_r >> 1;
        end
    end

    // ========================================================
    // units
    // ========================================================
    for (genvar g = 0; g < NUNIT; g++) begin : g_unit      // see RQ7
        logic                 wr_hit;
        logic                 ctl_wr;
        logic                 oneshot;
        tcp_pkg::tcp_mode_t   mode;
        tcp_pkg::tcp_ksrc_t   ksrc;
        logic                 kill;
        logic                 pwm_raw;

        assign wr_hit  = wr_i && (sel_unit == tcp_pkg::UNIT_W'(g));
        assign ctl_wr  = wr_hit && (sel_off == tcp_pkg::OFF_CTRL);
        assign oneshot = ctrl_r[g][tcp_pkg::CTL_ONESHOT];
        assign mode    = tcp_pkg::tcp_mode_t'(
                             ctrl_r[g][tcp_pkg::CTL_MODE_LO +: 2]);
        assign ksrc    = tcp_pkg::tcp_ksrc_t'(
                             ctrl_r[g][tcp_pkg::CTL_KSRC_LO +: 2]);

        // configuration registers
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                ctrl_r[g]   <= tcp_pkg::CTRL_RST;
                period_r[g] <= tcp_pkg::PERIOD_RST;
                cmp_r[g]    <= tcp_pkg::CNT_ZERO;
                dead_r[g]   <= tcp_pkg::DEAD_ZERO;
            end else if (wr_hit) begin
                unique case (sel_off)
                    tcp_pkg::OFF_CTRL:   ctrl_r[g]   <= wdata_i[7:0];
                    tcp_pkg::OFF_PERIOD: period_r[g] <= wdata_i[CW-1:0];
                    tcp_pkg::OFF_CMP:    cmp_r[g]    <= wdata_i[CW-1:0];
                    tcp_pkg::OFF_DEAD:   dead_r[g]   <= wdata_i[7:0];
                    default: ;
                endcase
            end
        end

        // counter: a control write with enable set restarts from zero
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin                              // see RQ10
                count_r[g] <= tcp_pkg::CNT_ZERO;
                run_r[g]   <= 1'b0;
                down_r[g]  <= 1'b0;
            end else if (ctl_wr) begin
                count_r[g] <= tcp_pkg::CNT_ZERO;
                run_r[g]   <= wdata_i[tcp_pkg::CTL_EN];
                down_r[g]  <= 1'b0;
            end else if (run_r[g]) begin                    // see RQ1
                if (mode == tcp_pkg::TCP_MODE_CENTER) begin // see RQ8
                    if (!down_r[g]) begin
                        if (count_r[g] == period_r[g]) begin
                            if (oneshot) begin              // see RQ3
                                run_r[g] <= 1'b0;
                            end else if (count_r[g] != '0) begin
                                down_r[g]  <= 1'b1;
                                count_r[g] <= count_r[g] - CNT_ONE_W;
                            end
                        end else begin
                            count_r[g] <= count_r[g] + CNT_ONE_W;
                        end
                    end else if (count_r[g] == '0) begin
                        down_r[g]  <= 1'b0;
                        count_r[g] <= (period_r[g] == '0) ?
                                      tcp_pkg::CNT_ZERO : CNT_ONE_W;
                    end else begin
                        count_r[g] <= count_r[g] - CNT_ONE_W;
                    end
                end else if (count_r[g] == period_r[g]) begin // see RQ3
                    if (oneshot) begin
                        run_r[g] <= 1'b0;
                    end else begin
                        count_r[g] <= tcp_pkg::CNT_ZERO;
                    end
                end else begin
                    count_r[g] <= count_r[g] + CNT_ONE_W;
                end
            end
        end

        // capture on the rising edge of the event input
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                cap_q_r[g] <= 1'b0;
                capt_r[g]  <= tcp_pkg::CNT_ZERO;
            end else begin
                cap_q_r[g] <= capture_i[g];
                if (capture_i[g] && !cap_q_r[g]) begin      // see RQ2
                    capt_r[g] <= count_r[g];
                end
            end
        end

        // duty compare; prng mode compares cmp with the shared LFSR, so its duty is set by the LFSR range, not the period
        always_comb begin
            unique case (mode)                              // see RQ8
                tcp_pkg::TCP_MODE_PRNG:
                    pwm_raw = run_r[g] && (lfsr_r < cmp_r[g]);
                default:                                    // see RQ4
                    pwm_raw = run_r[g] && (count_r[g] < cmp_r[g]);
            endcase
        end

        always_comb begin
            unique case (ksrc)                              // see RQ9
                tcp_pkg::TCP_KILL_PIN:  kill = kill_i[g];
                tcp_pkg::TCP_KILL_CMP0: kill = cmp_i[0];
                tcp_pkg::TCP_KILL_CMP1: kill = cmp_i[1];
                default:                kill = 1'b0;
            endcase
        end

        tcp_dead #(
            .DEAD_W (tcp_pkg::DEAD_W)
        ) u_dead (
            .clk_i    (clk_i),
            .reset_i  (reset_i),
            .pwm_i    (pwm_raw),
            .dead_i   (dead_r[g]),
            .kill_i   (kill),
            .safe_t_i (ctrl_r[g][tcp_pkg::CTL_SAFE_T]),
            .safe_c_i (ctrl_r[g][tcp_pkg::CTL_SAFE_C]),
            .out_o    (pwm_o[g]),
            .out_n_o  (pwm_n_o[g])
        );

        // ====================================================
        // checks
        // ====================================================
        chk_count_step: assert property ( // see RQ1
            @(posedge clk_i) disable iff (reset_i)
            run_r[g] && !ctl_wr && mode == tcp_pkg::TCP_MODE_EDGE &&
            count_r[g] != period_r[g]
            |=> count_r[g] == $past(count_r[g]) + CNT_ONE_W)
            else $error("counter did not step by one");

        chk_capture_copy: assert property ( // see RQ2
            @(posedge clk_i) disable iff (reset_i)
            capture_i[g] && !cap_q_r[g]
            |=> capt_r[g] == $past(count_r[g]))
            else $error("capture missed the count");

        chk_reload_wrap: assert property ( // see RQ3
            @(posedge clk_i) disable iff (reset_i)
            run_r[g] && !ctl_wr && !oneshot &&
            mode == tcp_pkg::TCP_MODE_EDGE && count_r[g] == period_r[g]
            |=> run_r[g] && count_r[g] == tcp_pkg::CNT_ZERO)
            else $error("no reload at period");

        chk_oneshot_stop: assert property ( // see RQ3
            @(posedge clk_i) disable iff (reset_i)
            run_r[g] && !ctl_wr && oneshot && !down_r[g] &&
            count_r[g] == period_r[g]
            |=> !run_r[g] ##1 (!run_r[g] || $past(ctl_wr)))
            else $error("one-shot did not stop");

        chk_edge_duty: assert property ( // see RQ4
            @(posedge clk_i) disable iff (reset_i)
            mode == tcp_pkg::TCP_MODE_EDGE && run_r[g] &&
            count_r[g] < cmp_r[g] |-> pwm_raw)
            else $error("duty compare wrong");

        chk_center_turn: assert property ( // see RQ8
            @(posedge clk_i) disable iff (reset_i)
            run_r[g] && !ctl_wr && !oneshot && !down_r[g] &&
            mode == tcp_pkg::TCP_MODE_CENTER &&
            count_r[g] == period_r[g] && period_r[g] != '0
            |=> down_r[g] && count_r[g] == $past(period_r[g]) - CNT_ONE_W)
            else $error("center mode did not turn");

        chk_kill_source: assert property ( // see RQ9
            @(posedge clk_i) disable iff (reset_i)
            ksrc == tcp_pkg::TCP_KILL_CMP0 && cmp_i[0]
            |=> pwm_o[g] == $past(ctrl_r[g][tcp_pkg::CTL_SAFE_T]))
            else $error("comparator kill ignored");

        chk_reset_idle: assert property ( // see RQ10
            @(posedge clk_i)
            reset_i |-> !pwm_o[g] && !pwm_n_o[g] && count_r[g] == '0)
            else $error("outputs active in reset");

        cov_wrap: cover property (
            @(posedge clk_i) disable iff (reset_i)
            run_r[g] && count_r[g] == period_r[g] ##1 count_r[g] == '0);
        cov_capture: cover property (
            @(posedge clk_i) disable iff (reset_i)
            capture_i[g] && !cap_q_r[g] && run_r[g]);
        cov_kill: cover property (
            @(posedge clk_i) disable iff (reset_i)
            kill ##1 !kill);
    end

    // ========================================================
    // register read
    // ========================================================
    always_comb begin
        rd_nxt = tcp_pkg::DATA_ZERO;
        if (32'(sel_unit) < NUNIT) begin
            unique case (sel_off)
                tcp_pkg::OFF_CTRL:   rd_nxt[7:0]    = ctrl_r[sel_unit];
                tcp_pkg::OFF_PERIOD: rd_nxt[CW-1:0] = period_r[sel_unit];
                tcp_pkg::OFF_CMP:    rd_nxt[CW-1:0] = cmp_r[sel_unit];
                tcp_pkg::OFF_DEAD:   rd_nxt[7:0]    = dead_r[sel_unit];
                tcp_pkg::OFF_CAPT:   rd_nxt[CW-1:0] = capt_r[sel_unit];
                tcp_pkg::OFF_STAT: begin
                    rd_nxt[CW-1:0]             = count_r[sel_unit];
                    rd_nxt[tcp_pkg::STAT_RUN]  = run_r[sel_unit];
                    rd_nxt[tcp_pkg::STAT_DOWN] = down_r[sel_unit];
                end
                default: ;
            endcase
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= tcp_pkg::DATA_ZERO;
        end else if (rd_i) begin
            rdata_o <= rd_nxt;
        end else begin
            rdata_o <= tcp_pkg::DATA_ZERO;
        end
    end

endmodule : tcp_top

`default_nettype wire

/* File: sim/tcp_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// far-side switch pairs: shoot-through watch, leg 0 timing
// ============================================================
module tcp_switch_model #(
    parameter int N = 5
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // switch gates
    input  wire logic [N-1:0] hi_i,
    input  wire logic [N-1:0] lo_i,
    // window: stats clear while low
    input  wire logic         meas_i,
    // results
    output logic      [15:0]  hi_cnt_o,
    output logic      [15:0]  lo_cnt_o,
    output logic      [15:0]  gap_min_o,
    output logic      [15:0]  gap_max_o,
    output logic              shoot_o
);
    logic [15:0] run_r;
    logic        armed_r;
    wire logic   off_w = !hi_i[0] && !lo_i[0];

    // both switches on shorts the supply; sticky until reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i)
            shoot_o <= 1'b0;
        else if (|(hi_i & lo_i))
            shoot_o <= 1'b1;
    end

    // first gap in a window may be cut short, so it is not recorded
    always_ff @(posedge clk_i) begin
        if (!meas_i) begin
            hi_cnt_o  <= 16'h0000;
            lo_cnt_o  <= 16'h0000;
            gap_min_o <= 16'hFFFF;
            gap_max_o <= 16'h0000;
            run_r     <= 16'h0000;
            armed_r   <= 1'b0;
        end else begin
            hi_cnt_o <= hi_cnt_o + 16'(hi_i[0]);
            lo_cnt_o <= lo_cnt_o + 16'(lo_i[0]);
            if (off_w) begin
                run_r <= run_r + 16'h0001;
            end else if (run_r != 16'h0000) begin
                run_r   <= 16'h0000;
                armed_r <= 1'b1;
                if (armed_r && run_r < gap_min_o)
                    gap_min_o <= run_r;
                if (armed_r && run_r > gap_max_o)
                    gap_max_o <= run_r;
            end
        end
    end
endmodule : tcp_switch_model

`default_nettype wire

/* File: sim/tcp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_top_tb;
    logic        clk_i, reset_i, wr_i, rd_i, meas, shoot;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, d, ctl;
    logic [4:0]  capture_i, kill_i, pwm_o, pwm_n_o;
    logic [1:0]  cmp_i, md[3];
    logic [15:0] hi_cnt, lo_cnt, gap_min, gap_max;
    logic [4:0]  offs[5];
    logic [31:0] rstv[5];
    int          fails, compares, dead_t[3], cmp_t[3];

    tcp_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .capture_i(capture_i), .kill_i(kill_i), .cmp_i(cmp_i),
        .pwm_o(pwm_o), .pwm_n_o(pwm_n_o));

    tcp_switch_model u_sw (.clk_i(clk_i), .reset_i(reset_i),
        .hi_i(pwm_o), .lo_i(pwm_n_o), .meas_i(meas), .hi_cnt_o(hi_cnt),
        .lo_cnt_o(lo_cnt), .gap_min_o(gap_min), .gap_max_o(gap_max),
        .shoot_o(shoot));

    // ========================================================
    // bus and check tasks
    // ========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input int u, input logic [4:0] o,
                      input logic [31:0] v);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= {u[2:0], o};
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input int u, input logic [4:0] o,
                      output logic [31:0] v);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= {u[2:0], o};
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask : rd

    // settle, then a window of exactly 100 sampled edges
    task automatic measure;
        meas <= 1'b0;
        repeat (40) @(posedge clk_i);
        meas <= 1'b1;
        repeat (100) @(posedge clk_i);
        @(negedge clk_i);
    endtask : measure

    task automatic report_and_stop;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        report_and_stop();
    end

    // ========================================================
    // tests
    // ========================================================
    initial begin
        {reset_i, wr_i, rd_i, meas} = 4'b1000;
        {addr_i, wdata_i, capture_i, kill_i, cmp_i} = '0;
        offs = '{tcp_pkg::OFF_CTRL, tcp_pkg::OFF_PERIOD, tcp_pkg::OFF_CMP,
                 tcp_pkg::OFF_DEAD, tcp_pkg::OFF_CAPT};
        rstv = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000,
                 32'h0000_0000, 32'h0000_0000};
        dead_t = '{0, 1, 3};
        cmp_t  = '{4, 4, 5};
        md = '{tcp_pkg::TCP_MODE_CENTER, tcp_pkg::TCP_MODE_PRNG, 2'b11};
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        chk(32'({pwm_o, pwm_n_o}), 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            rd(4, offs[i], d);
            chk(d, rstv[i]);
        end
        $display("test reset values done");

        for (int u = 0; u < 5; u++)
            wr(u, tcp_pkg::OFF_PERIOD, 32'h0001_0100 + u);
        wr(5, tcp_pkg::OFF_PERIOD, 32'h0000_0055);
        wr(3, tcp_pkg::OFF_CAPT, 32'h0000_AAAA);
        wr(2, tcp_pkg::OFF_DEAD, 32'h0000_01FF);
        for (int u = 0; u < 5; u++) begin
            rd(u, tcp_pkg::OFF_PERIOD, d);
            chk(d, 32'h0000_0100 + u);
        end
        rd(5, tcp_pkg::OFF_PERIOD, d);
        chk(d, 32'h0000_0000);
        rd(0, 5'h18, d);
        chk(d, 32'h0000_0000);
        rd(3, tcp_pkg::OFF_CAPT, d);
        chk(d, 32'h0000_0000);
        rd(2, tcp_pkg::OFF_DEAD, d);
        chk(d, 32'h0000_00FF);
        $display("test map done");

        wr(0, tcp_pkg::OFF_PERIOD, 32'h0000_0005);
        wr(0, tcp_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (20) @(posedge clk_i);
        rd(0, tcp_pkg::OFF_STAT, d);
        chk(d, 32'h0000_0005);
        @(posedge clk_i);
        capture_i[0] <= 1'b1;
        @(posedge clk_i);
        capture_i[0] <= 1'b0;
        rd(0, tcp_pkg::OFF_CAPT, d);
        chk(d, 32'h0000_0005);
        wr(0, tcp_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (23) @(posedge clk_i);
        rd(0, tcp_pkg::OFF_STAT, d);
        chk(32'(d[16]), 32'h0000_0001);
        chk(32'(d[15:0] <= 16'h0005), 32'h0000_0001);
        $display("test counter done");

        wr(0, tcp_pkg::OFF_PERIOD, 32'h0000_0009);
        for (int k = 0; k < 3; k++) begin
            wr(0, tcp_pkg::OFF_CMP, 32'(cmp_t[k]));
            wr(0, tcp_pkg::OFF_DEAD, 32'(dead_t[k]));
            wr(0, tcp_pkg::OFF_CTRL, 32'h0000_0001);
            measure();
            chk(32'(hi_cnt), 32'(10 * (cmp_t[k] - dead_t[k] - 1)));
            chk(32'(lo_cnt), 32'(10 * (9 - cmp_t[k] - dead_t[k])));
            chk(32'(gap_min), 32'(dead_t[k] + 1));
            chk(32'(gap_max), 32'(dead_t[k] + 1));
        end
        $display("test duty and dead band done");

        wr(0, tcp_pkg::OFF_DEAD, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wr(0, tcp_pkg::OFF_CMP, (k == 1) ? 32'h0000_8000 : 32'h0000_0005);
            ctl = 32'h0000_0001 | (32'(md[k]) << tcp_pkg::CTL_MODE_LO);
            wr(0, tcp_pkg::OFF_CTRL, ctl);
            measure();
            chk(32'(hi_cnt != 16'h0000), 32'h0000_0001);
            chk(32'(lo_cnt != 16'h0000), 32'h0000_0001);
        end
        chk(32'(hi_cnt), 32'h0000_0028);
        $display("test modes done");

        @(posedge clk_i);
        kill_i <= 5'h1F;
        wr(0, tcp_pkg::OFF_CTRL, 32'h0000_0001);
        measure();
        chk(32'(hi_cnt), 32'h0000_0028);
        kill_i <= 5'h00;
        for (int s = 1; s < 4; s++) begin
            ctl = 32'h0000_0001 | (32'(s) << tcp_pkg::CTL_KSRC_LO)
                | (32'(s % 2) << tcp_pkg::CTL_SAFE_T)
                | (32'(1 - s % 2) << tcp_pkg::CTL_SAFE_C);
            wr(0, tcp_pkg::OFF_CTRL, ctl);
            repeat (20) @(posedge clk_i);
            if (s == 1)
                kill_i[0] <= 1'b1;
            else
                cmp_i[s-2] <= 1'b1;
            repeat (3) @(posedge clk_i);
            d = 32'(s % 2 * 2 + 1 - s % 2);
            for (int i = 0; i < 12; i++) begin
                @(negedge clk_i);
                chk(32'({pwm_o[0], pwm_n_o[0]}), d);
            end
            @(posedge clk_i);
            kill_i <= 5'h00;
            cmp_i  <= 2'b00;
        end
        repeat (20) @(posedge clk_i);
        chk(32'(shoot), 32'h0000_0000);
        $display("test kill done");

        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(32'({pwm_o, pwm_n_o}), 32'h0000_0000);
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd(0, tcp_pkg::OFF_STAT, d);
        chk(d, 32'h0000_0000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tcp_top_tb

`default_nettype wire
